// >>> hw/clt_params.svh
// Constants for the co-directional line timing and loopback channel
`ifndef CLT_PARAMS_SVH
`define CLT_PARAMS_SVH

// System clock and fixed line rate (no configurable rate applies)
`define CLT_CLK_HZ      50000000
`define CLT_LINE_BPS    64000
`define CLT_OCTET_HZ    8000
// Bit period in clock cycles, rounded down: 781
`define CLT_BIT_CYC     (`CLT_CLK_HZ / `CLT_LINE_BPS)
`define CLT_HALF_CYC    (`CLT_BIT_CYC / 2)
`define CLT_CNT_W       10
// Bits per octet; the marked bit is the last one (LSB, bit 8)
`define CLT_OCT_BITS    (`CLT_LINE_BPS / `CLT_OCTET_HZ)
`define CLT_OCT_LAST    3'h7

// Positions in the synchronised pin vector
`define CLT_PIN_OCT     0
`define CLT_PIN_SWA     1
`define CLT_PIN_SWB     2
`define CLT_PIN_RXD     3
`define CLT_PIN_RXC     4
`define CLT_PIN_N       5

// Reset values: multiplexer defaults, octet timing on
`define CLT_RST_OCT_EN  1'b1

`endif

// >>> hw/clt_pkg.sv
// Types shared by the line timing and loopback channel
package clt_pkg;

  // Operating modes selected by the two mode switches
  typedef enum logic [1:0] {
    CLT_LOOP_TIMING,
    CLT_INT_TIMING,
    CLT_MIN_REMOTE_LB,
    CLT_DUAL_LB
  } clt_mode_type;

  // One line-side transmit sample: timing level and data bit
  typedef struct packed {
    logic clk;
    logic data;
  } clt_line_type;

  // One bit toward the internal Manchester transmitter
  typedef struct packed {
    logic octet;
    logic data;
  } clt_word_type;

endpackage

// >>> hw/clt_buf2.sv
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module clt_buf2
  import clt_pkg::*;
(
  input  wire logic         clk,
  input  wire logic         sys_rst,
  input  wire logic         in_valid,
  input  wire clt_word_type in_data,
  output logic              in_ready,
  output logic              out_valid,
  output clt_word_type      out_data,
  input  wire logic         out_ready
);

  logic         main_v_q;
  logic         skid_v_q;
  clt_word_type skid_q;
  wire          take = in_valid && in_ready;
  wire          give = out_valid && out_ready;

  // Outputs come straight from flops; skid slot catches the stalled word
  assign in_ready  = !skid_v_q;
  assign out_valid = main_v_q;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      main_v_q <= 1'b0;
      skid_v_q <= 1'b0;
      out_data <= '0;
      skid_q   <= '0;
    end else if (!main_v_q || give) begin
      main_v_q <= skid_v_q || take;
      out_data <= skid_v_q ? skid_q : in_data;
      skid_v_q <= skid_v_q && take;
      if (skid_v_q && take) begin
        skid_q <= in_data;
      end
    end else if (take) begin
      skid_v_q <= 1'b1;
      skid_q   <= in_data;
    end
  end

endmodule

// >>> hw/clt_top.sv
// Co-directional 64 kbps line channel: timing selection and loopbacks
//
// Operation
// - With octet timing on in loop or internal timing mode, an 8 kHz marker is raised during bit 8 (LSB) of each octet.
// - Internal timing mode clocks the transmitter from the internal bit counter.
// - Loop timing mode clocks the transmitter from timing recovered off the line.
// - Minimum remote loopback returns the latched, polarity-restored line input to the line.
// - Minimum remote loopback still processes internal-side data, then discards it.
// - Minimum remote loopback keeps forwarding decoded line data to the internal side.
// - Minimum remote loopback returns timing as received; the line side supplies it.
// - Dual loopback sends internal receiver data straight back to the internal transmitter.
// - Dual loopback sends line receiver data straight back to the line transmitter.
// - Dual loopback rebuilds each loop on its own recovered timing; both sides need sources.
// - The default state is octet timing on with loop timing mode.
// - The octet switch off disables octet timing; on selects 8 kHz octet timing.
// - Mode switches decode: off/off loop, a only internal, b only min loopback, both dual.
// - The line rate is fixed at 64 kbps regardless of any rate setting.
`timescale 1ns/1ps
`include "clt_params.svh"
module clt_top
  import clt_pkg::*;
(
  input  wire logic   clk,
  input  wire logic   sys_rst,
  input  wire logic   octet_timing_switch,
  input  wire logic   mode_select_switch_a,
  input  wire logic   mode_select_switch_b,
  input  wire logic   line_rx_bit,
  input  wire logic   line_rx_clk,
  input  wire logic   line_rx_pol_inv,
  input  wire logic   dm_rx_valid,
  input  wire logic   dm_rx_bit,
  input  wire logic   dm_tx_ready,
  output logic        dm_tx_valid,
  output clt_word_type dm_tx_word,
  output clt_line_type line_tx,
  output logic        octet_marker,
  output clt_mode_type mode,
  output logic        octet_enable,
  output logic        dm_overrun
);

  // Mode decode, shared by the logic and its checks
  function automatic clt_mode_type clt_decode(input logic a, input logic b);
    clt_decode = b ? (a ? CLT_DUAL_LB : CLT_MIN_REMOTE_LB)
                   : (a ? CLT_INT_TIMING : CLT_LOOP_TIMING);
  endfunction

  logic [`CLT_PIN_N-1:0] pin_vec;
  logic [`CLT_PIN_N-1:0] s1_q;
  logic [`CLT_PIN_N-1:0] s2_q;
  logic [`CLT_PIN_N-1:0] s3_q;
  logic [`CLT_PIN_N-1:0] lvl_q;
  logic                  rxc_prev_q;
  logic [`CLT_CNT_W-1:0] int_cnt_q;
  logic [2:0]            oct_cnt_q;
  logic                  dm_hold_q;
  logic                  buf_in_ready;

  assign pin_vec = {line_rx_clk, line_rx_bit, mode_select_switch_b,
                    mode_select_switch_a, octet_timing_switch};

  // Three-stage synchronisers; a level counts once stages two and three agree
  genvar gi;
  generate
    for (gi = 0; gi < `CLT_PIN_N; gi++) begin : g_sync
      always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
          s1_q[gi]  <= 1'b0;
          s2_q[gi]  <= 1'b0;
          s3_q[gi]  <= 1'b0;
          lvl_q[gi] <= 1'b0;
        end else begin
          s1_q[gi]  <= pin_vec[gi];
          s2_q[gi]  <= s1_q[gi];
          s3_q[gi]  <= s2_q[gi];
          lvl_q[gi] <= (s2_q[gi] == s3_q[gi]) ? s3_q[gi] : lvl_q[gi];
        end
      end
    end
  endgenerate

  // Named decode and selection terms
  wire          sw_a      = lvl_q[`CLT_PIN_SWA];
  wire          sw_b      = lvl_q[`CLT_PIN_SWB];
  wire          rx_data   = lvl_q[`CLT_PIN_RXD] ^ line_rx_pol_inv;
  wire          rx_clk    = lvl_q[`CLT_PIN_RXC];
  wire          rx_rise   = rx_clk && !rxc_prev_q;
  wire          int_tick  = (int_cnt_q == `CLT_CNT_W'(`CLT_BIT_CYC - 1));
  wire          timing_md = (mode == CLT_LOOP_TIMING) || (mode == CLT_INT_TIMING);
  // Internal counter only in internal mode; every other mode follows the line
  wire          tx_tick   = (mode == CLT_INT_TIMING) ? int_tick : rx_rise;
  wire          int_clk   = (int_cnt_q < `CLT_CNT_W'(`CLT_HALF_CYC));
  wire [2:0]    oct_nxt   = (oct_cnt_q == `CLT_OCT_LAST) ? 3'h0 : oct_cnt_q + 3'h1;
  wire          dual      = (mode == CLT_DUAL_LB);
  // Toward the internal side: line data, or in dual loopback its own data
  wire          buf_in_v  = dual ? dm_rx_valid : rx_rise;
  clt_word_type buf_in_w;
  assign buf_in_w = '{octet: octet_enable && timing_md && (oct_cnt_q == `CLT_OCT_LAST),
                      data:  dual ? dm_rx_bit : rx_data};

  // Mode and octet enable follow the switches; reset gives mux defaults
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      mode         <= CLT_LOOP_TIMING;
      octet_enable <= `CLT_RST_OCT_EN;
      rxc_prev_q   <= 1'b0;
    end else begin
      mode         <= clt_decode(sw_a, sw_b);
      octet_enable <= lvl_q[`CLT_PIN_OCT];
      rxc_prev_q   <= rx_clk;
    end
  end

  // Free-running internal bit timer at the fixed line rate
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      int_cnt_q <= '0;
    end else begin
      int_cnt_q <= int_tick ? '0 : int_cnt_q + `CLT_CNT_W'(1);
    end
  end

  // Internal-side data is always captured, even when the line ignores it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dm_hold_q <= 1'b0;
    end else if (dm_rx_valid) begin
      dm_hold_q <= dm_rx_bit;
    end
  end

  // Octet position counter and the bit-8 marker
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      oct_cnt_q    <= '0;
      octet_marker <= 1'b0;
    end else if (!octet_enable || !timing_md) begin
      oct_cnt_q    <= '0;
      octet_marker <= 1'b0;
    end else if (tx_tick) begin
      oct_cnt_q    <= oct_nxt;
      octet_marker <= (oct_nxt == `CLT_OCT_LAST);
    end
  end

  // Line transmitter: source and timing per mode
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      line_tx <= '0;
    end else begin
      case (mode)
        CLT_MIN_REMOTE_LB: begin
          // Latched input straight back, no retiming, any rate
          line_tx.data <= rx_data;
          line_tx.clk  <= rx_clk;
        end
        CLT_DUAL_LB: begin
          line_tx.clk <= rx_clk;
          if (rx_rise) begin
            line_tx.data <= rx_data;
          end
        end
        CLT_INT_TIMING: begin
          line_tx.clk <= int_clk;
          if (tx_tick) begin
            line_tx.data <= dm_hold_q;
          end
        end
        default: begin
          line_tx.clk <= rx_clk;
          if (tx_tick) begin
            line_tx.data <= dm_hold_q;
          end
        end
      endcase
    end
  end

  // A word arriving while the buffer is full cannot stall the line; flag it
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dm_overrun <= 1'b0;
    end else if (buf_in_v && !buf_in_ready) begin
      dm_overrun <= 1'b1;
    end
  end

  // Buffer toward the internal Manchester transmitter
  clt_buf2 i_clt_buf2 (
    .clk       (clk),
    .sys_rst   (sys_rst),
    .in_valid  (buf_in_v),
    .in_data   (buf_in_w),
    .in_ready  (buf_in_ready),
    .out_valid (dm_tx_valid),
    .out_data  (dm_tx_word),
    .out_ready (dm_tx_ready)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  property p_oct_mark;
    octet_enable && timing_md && tx_tick && oct_cnt_q == 3'h6 |=> octet_marker;
  endproperty
  a_oct_mark: assert property (p_oct_mark) else $error("octet marker missing on bit 8");

  property p_oct_off;
    !octet_enable |=> !octet_marker;
  endproperty
  a_oct_off: assert property (p_oct_off) else $error("octet marker while disabled");

  property p_int_clk;
    mode == CLT_INT_TIMING && $past(mode) == CLT_INT_TIMING |-> line_tx.clk == $past(int_clk);
  endproperty
  a_int_clk: assert property (p_int_clk) else $error("internal timing not used");

  property p_loop_clk;
    mode == CLT_LOOP_TIMING |=> line_tx.clk == $past(rx_clk);
  endproperty
  a_loop_clk: assert property (p_loop_clk) else $error("loop timing not followed");

  property p_mrl_data;
    mode == CLT_MIN_REMOTE_LB |=> line_tx.data == $past(rx_data);
  endproperty
  a_mrl_data: assert property (p_mrl_data) else $error("min loopback data not returned");

  // Both loopbacks hand the received line timing straight back out
  property p_lb_clk;
    (mode == CLT_MIN_REMOTE_LB || mode == CLT_DUAL_LB) |=> line_tx.clk == $past(rx_clk);
  endproperty
  a_lb_clk: assert property (p_lb_clk) else $error("loopback timing not returned");

  property p_mrl_hold;
    mode == CLT_MIN_REMOTE_LB && dm_rx_valid |=> dm_hold_q == $past(dm_rx_bit);
  endproperty
  a_mrl_hold: assert property (p_mrl_hold) else $error("internal data not processed");

  property p_fwd_line;
    mode != CLT_DUAL_LB && rx_rise && buf_in_ready && !i_clt_buf2.main_v_q
      |=> dm_tx_valid && dm_tx_word.data == $past(rx_data);
  endproperty
  a_fwd_line: assert property (p_fwd_line) else $error("line data not forwarded");

  property p_dual_dm;
    mode == CLT_DUAL_LB && dm_rx_valid && buf_in_ready && !i_clt_buf2.main_v_q
      |=> dm_tx_valid && dm_tx_word.data == $past(dm_rx_bit);
  endproperty
  a_dual_dm: assert property (p_dual_dm) else $error("dual loop internal path broken");

  property p_dual_line;
    mode == CLT_DUAL_LB && $past(mode) == CLT_DUAL_LB && rx_rise
      |=> line_tx.data == $past(rx_data);
  endproperty
  a_dual_line: assert property (p_dual_line) else $error("dual loop line path broken");

  property p_mode_dec;
    ##1 mode == clt_decode($past(sw_a), $past(sw_b));
  endproperty
  a_mode_dec: assert property (p_mode_dec) else $error("mode decode wrong");

  property p_int_tx;
    mode == CLT_INT_TIMING && tx_tick |=> line_tx.data == $past(dm_hold_q);
  endproperty
  a_int_tx: assert property (p_int_tx) else $error("internal data not sent");

  c_marker: cover property (octet_marker ##1 !octet_marker);
  c_mrl:    cover property (mode == CLT_MIN_REMOTE_LB && rx_rise);
  c_dual:   cover property (mode == CLT_DUAL_LB && dm_rx_valid);
  c_stall:  cover property (!buf_in_ready && !dm_tx_ready);

endmodule

// >>> verif/clt_line_peer.sv
// Line-side peer model: repeating byte with its own bit timing
`timescale 1ns/1ps
module clt_line_peer (
  input  wire logic clk,
  input  wire logic run,
  output logic      rx_clk,
  output logic      rx_bit
);
  logic [7:0] pat_q;
  logic [3:0] cnt_q;

  initial begin
    rx_clk = 1'b0;
    rx_bit = 1'b0;
    pat_q = 8'ha5;
    cnt_q = 4'h0;
  end

  // Clock stands still between runs; idle data toggles so stale values never match
  always @(posedge clk) begin
    if (!run) begin
      rx_clk <= 1'b0;
      rx_bit <= ~rx_bit;
      cnt_q <= 4'h0;
    end else if (cnt_q == 4'h9) begin
      cnt_q <= 4'h0;
      rx_clk <= ~rx_clk;
      // New bit on the falling edge, steady 10 cycles around the rise
      if (rx_clk) begin
        rx_bit <= pat_q[7];
        pat_q <= {pat_q[6:0], pat_q[7]};
      end
    end else begin
      cnt_q <= cnt_q + 4'h1;
    end
  end
endmodule

// >>> verif/clt_top_tb.sv
// Self-checking bench for the line timing and loopback channel
`timescale 1ns/1ps
module clt_top_tb;
  import clt_pkg::*;
  logic         clk = 1'b0;
  logic         sys_rst = 1'b1;
  logic         oct_sw = 1'b1;
  logic         sw_a = 1'b0;
  logic         sw_b = 1'b0;
  logic         pol = 1'b0;
  logic         dm_v = 1'b0;
  logic         dm_b = 1'b0;
  logic         rdy = 1'b1;
  logic         run = 1'b0;
  logic         rx_clk;
  logic         rx_bit;
  logic         dm_tx_valid;
  clt_word_type dm_tx_word;
  clt_line_type line_tx;
  logic         octet_marker;
  clt_mode_type mode;
  logic         octet_enable;
  logic         dm_overrun;
  clt_word_type q[$];
  logic         lc_q = 1'b0;
  int           gap_cnt = 0;
  int           gap = 0;
  int           num_errors = 0;
  int           compares = 0;

  always #10 clk = ~clk;

  clt_top i_clt_top (.clk(clk), .sys_rst(sys_rst), .octet_timing_switch(oct_sw),
    .mode_select_switch_a(sw_a), .mode_select_switch_b(sw_b), .line_rx_bit(rx_bit),
    .line_rx_clk(rx_clk), .line_rx_pol_inv(pol), .dm_rx_valid(dm_v), .dm_rx_bit(dm_b),
    .dm_tx_ready(rdy), .dm_tx_valid(dm_tx_valid), .dm_tx_word(dm_tx_word),
    .line_tx(line_tx), .octet_marker(octet_marker), .mode(mode),
    .octet_enable(octet_enable), .dm_overrun(dm_overrun));

  clt_line_peer i_clt_line_peer (.clk(clk), .run(run), .rx_clk(rx_clk), .rx_bit(rx_bit));

  // Collect accepted words and the spacing of transmit clock rises
  always @(posedge clk) begin
    if (dm_tx_valid && rdy) q.push_back(dm_tx_word);
    lc_q <= line_tx.clk;
    gap_cnt <= (line_tx.clk && !lc_q) ? 1 : gap_cnt + 1;
    if (line_tx.clk && !lc_q) gap <= gap_cnt;
  end

  task automatic check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL %s exp %h got %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask

  // Switch change plus synchroniser settling
  task automatic setm(input logic a, input logic b, input logic o);
    @(posedge clk);
    sw_a <= a;
    sw_b <= b;
    oct_sw <= o;
    cyc(8);
  endtask

  task automatic dm_send(input logic b);
    @(posedge clk);
    dm_v <= 1'b1;
    dm_b <= b;
    @(posedge clk);
    dm_v <= 1'b0;
  endtask

  // Window of 8 bit periods at the peer's rate
  task automatic count_mk(output int n);
    n = 0;
    repeat (160) begin
      @(posedge clk);
      if (octet_marker === 1'b1) n++;
    end
  endtask

  task automatic t_decode;
    for (int i = 0; i < 4; i++) begin
      setm(i[0], i[1], i[0]);
      check("mode", mode, i[1:0]);
      check("octet_enable", octet_enable, i[0]);
    end
  endtask

  task automatic t_int;
    int n;
    setm(1'b1, 1'b0, 1'b0);
    dm_send(1'b1);
    cyc(1700);
    check("int_gap", gap, 781);
    check("int_dm_to_line", line_tx.data, 1'b1);
    count_mk(n);
    check("marker_off", n, 0);
    dm_send(1'b0);
    cyc(1600);
    check("int_dm_to_line", line_tx.data, 1'b0);
  endtask

  task automatic t_loop;
    int n;
    int s;
    setm(1'b0, 1'b0, 1'b1);
    run <= 1'b1;
    cyc(400);
    check("loop_gap", gap, 20);
    count_mk(n);
    check("marker_cycles", n, 20);
    n = 0;
    s = 0;
    for (int i = q.size() - 8; i < q.size(); i++) begin
      check("word_repeat", q[i], q[i - 8]);
      n += q[i].octet;
      s += q[i].data;
    end
    check("octet_flags", n, 1);
    check("ones_per_octet", s, 4);
    dm_send(1'b1);
    cyc(60);
    check("loop_dm_to_line", line_tx.data, 1'b1);
  endtask

  task automatic t_mrl;
    int qs;
    setm(1'b0, 1'b1, 1'b1);
    for (int p = 0; p < 2; p++) begin
      pol <= p[0];
      @(posedge rx_clk);
      dm_send(~rx_bit);
      cyc(6);
      check("mrl_echo", line_tx.data, rx_bit ^ p[0]);
    end
    qs = q.size();
    cyc(100);
    check("mrl_forward", q.size() > qs, 1'b1);
    run <= 1'b0;
    pol <= 1'b0;
    cyc(20);
    check("mrl_clk_still", line_tx.clk, 1'b0);
  endtask

  task automatic t_dual;
    setm(1'b1, 1'b1, 1'b1);
    rdy <= 1'b0;
    q.delete();
    dm_send(1'b1);
    dm_send(1'b0);
    dm_send(1'b1);
    cyc(2);
    check("overrun", dm_overrun, 1'b1);
    rdy <= 1'b1;
    run <= 1'b1;
    cyc(5);
    check("dm_loop_count", q.size(), 2);
    check("dm_loop_w0", q[0].data, 1'b1);
    check("dm_loop_w1", q[1].data, 1'b0);
    @(posedge rx_clk);
    cyc(8);
    check("line_loop", line_tx.data, rx_bit);
    cyc(100);
    check("isolation", q.size(), 2);
    check("dual_gap", gap, 20);
  endtask

  task automatic summarize;
    if (num_errors == 0 && compares > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    cyc(12);
    check("rst_mode", mode, CLT_LOOP_TIMING);
    check("rst_octet", octet_enable, 1'b1);
    sys_rst <= 1'b0;
    cyc(6);
    t_decode();
    t_int();
    t_loop();
    t_mrl();
    t_dual();
    summarize();
  end

  // Hang guard, several times the expected run length
  initial begin
    cyc(20000);
    num_errors++;
    summarize();
  end
endmodule
